// *** common/scm_consts.svh ***
// Constants of the supply control and monitor block
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

`define SCM_CLK_MHZ 100
`define SCM_RST_TIME_US 1000
`define SCM_RST_CYCLES (`SCM_RST_TIME_US * `SCM_CLK_MHZ)
`define SCM_RST_CNT_W 17
`define SCM_CY_BASE_MS 32
`define SCM_CY_CNT_W 9
`define SCM_CY_SEL_LONG 3'h7
`define SCM_CY_LONG_MS 8192
`define SCM_CY_ON_MS 1

// Interrupt source bit positions
`define SCM_IRQ_W 8
`define SCM_IRQ_BAT_LOW 0
`define SCM_IRQ_BAT_HIGH 1
`define SCM_IRQ_MCU_WARN 2
`define SCM_IRQ_MCU_SHUT 3
`define SCM_IRQ_PER_WARN 4
`define SCM_IRQ_PER_UV 5
`define SCM_IRQ_WAKE 6
`define SCM_IRQ_SW_OT 7

`define SCM_IEN_RESET 8'h00

`endif

// *** common/scm_pkg.sv ***
// Types of the supply control and monitor block
package scm_pkg;

    typedef enum logic [2:0] {
        SCM_NORMAL_REQ = 3'h0,
        SCM_NORMAL = 3'h1,
        SCM_STANDBY = 3'h2,
        SCM_SLEEP = 3'h3,
        SCM_EMERGENCY = 3'h4
    } scm_mode_e;

    // Analog comparator outputs, all active high
    typedef struct packed {
        logic bat_present;
        logic bat_low;
        logic bat_high;
        logic mcu_uv;
        logic mcu_warn;
        logic mcu_shut;
        logic per_uv;
        logic per_warn;
        logic per_shut;
        logic sw_warn;
        logic sw_shut;
    } scm_analog_s;

    // Software configuration
    typedef struct packed {
        logic mode_wr;
        scm_mode_e mode;
        logic per_enable_wr;
        logic sw_normal_on;
        logic sw_standby_on;
        logic sw_sleep_cyclic;
        logic [2:0] cyclic_sel;
        logic [2:0] wake_en;
    } scm_cfg_s;

    // Status flags seen at the flags_o output
    typedef struct packed {
        logic mcu_uv_reset;
        logic mcu_warn;
        logic mcu_shut;
        logic per_warn;
        logic per_shut;
        logic per_uv;
        logic bat_low;
        logic bat_high;
        logic sw_ot;
        logic wake;
    } scm_flags_s;

endpackage

// *** rtl/scm_tick.sv ***
// Millisecond tick divider from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.svh"
module scm_tick (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Tick
    output logic tick_o
);
    localparam int Div = `SCM_CLK_MHZ * 1000;
    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg + 17'h00001;
        if (cnt_reg == 17'(Div - 1)) begin
            cnt_next = 17'h00000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 17'h00000;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= (cnt_reg == 17'(Div - 1));
        end
    end
endmodule
`default_nettype wire

// *** rtl/scm_flag.sv ***
// Sticky status flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module scm_flag (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Set and clear
    input wire logic set_i,
    input wire logic clr_i,
    // Flag
    output logic flag_o
);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/scm_top.sv ***
// Supply control and monitor: modes, regulators, reset and interrupt lines
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.svh"
module scm_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Analog comparators
    input wire scm_pkg::scm_analog_s analog_i,
    // Wake inputs
    input wire logic [2:0] wake_inputs_i,
    // Reset line, open drain
    input wire logic mcu_rst_n_i,
    output logic mcu_rst_n_o,
    output logic mcu_rst_n_oe_o,
    // Software configuration
    input wire scm_pkg::scm_cfg_s cfg_i,
    input wire logic ien_wr_i,
    input wire logic [`SCM_IRQ_W-1:0] ien_data_i,
    input wire scm_pkg::scm_flags_s flag_clr_i,
    // Status
    output scm_pkg::scm_flags_s flags_o,
    output scm_pkg::scm_mode_e mode_o,
    output logic [2:0] wake_level_o,
    output logic [`SCM_IRQ_W-1:0] interrupt_enable_reg_o,
    // Interrupt line, active low
    output logic irq_line_n_o,
    // Supply enables
    output logic mcu_regulator_en_o,
    output logic peripheral_regulator_en_o,
    output logic battery_switch_en_o
);
    import scm_pkg::*;

    typedef struct packed {
        scm_mode_e mode;
        logic [`SCM_RST_CNT_W-1:0] rst_cnt;
        logic rst_drive;
        logic ext_rst_seen;
        logic mcu_uv_d;
        logic mcu_shut_latch;
        logic per_shut_latch;
        logic per_sw_en;
        logic sw_ot_latch;
        logic [13:0] cy_cnt;
        logic [2:0] wake_d;
        logic [`SCM_IRQ_W-1:0] ien;
        logic irq_n;
        logic mcu_en;
        logic per_en;
        logic sw_en;
        logic [2:0] wake_lvl;
    } scm_state_s;

    scm_state_s st_reg;
    scm_state_s st_next;
    logic ms_tick;
    logic wake_evt;
    scm_flags_s fl_set;
    scm_flags_s fl_q;
    logic [13:0] cy_period;
    logic [`SCM_IRQ_W-1:0] pend;
    logic mcu_on;
    logic per_on;
    logic sw_on;

    scm_tick u_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(ms_tick)
    );

    // One sticky flag per status bit
    for (genvar i = 0; i < $bits(scm_flags_s); i++) begin : g_flag
        scm_flag u_flag (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .set_i(fl_set[i]),
            .clr_i(flag_clr_i[i]),
            .flag_o(fl_q[i])
        );
    end

    // Period in ms: 32 << sel, last code is the long period
    always_comb begin
        if (cfg_i.cyclic_sel == `SCM_CY_SEL_LONG) begin
            cy_period = 14'(`SCM_CY_LONG_MS);
        end else begin
            cy_period = 14'(`SCM_CY_BASE_MS) << cfg_i.cyclic_sel;
        end
    end

    assign wake_evt = |((wake_inputs_i ^ st_reg.wake_d) & cfg_i.wake_en);

    always_comb begin
        fl_set = '0;
        fl_set.mcu_uv_reset = analog_i.mcu_uv & ~st_reg.mcu_uv_d;
        fl_set.mcu_warn = analog_i.mcu_warn;
        fl_set.mcu_shut = analog_i.mcu_shut;
        fl_set.per_warn = analog_i.per_warn;
        fl_set.per_shut = analog_i.per_shut;
        fl_set.per_uv = analog_i.per_uv;
        fl_set.bat_low = analog_i.bat_low;
        fl_set.bat_high = analog_i.bat_high;
        fl_set.sw_ot = analog_i.sw_shut;
        fl_set.wake = wake_evt && st_reg.mode == SCM_SLEEP;
    end

    // Pending sources in enable-register order
    always_comb begin
        pend = '0;
        pend[`SCM_IRQ_BAT_LOW] = fl_q.bat_low;
        pend[`SCM_IRQ_BAT_HIGH] = fl_q.bat_high;
        pend[`SCM_IRQ_MCU_WARN] = fl_q.mcu_warn;
        pend[`SCM_IRQ_MCU_SHUT] = fl_q.mcu_shut;
        pend[`SCM_IRQ_PER_WARN] = fl_q.per_warn;
        pend[`SCM_IRQ_PER_UV] = fl_q.per_uv;
        pend[`SCM_IRQ_WAKE] = fl_q.wake;
        pend[`SCM_IRQ_SW_OT] = fl_q.sw_ot;
    end

    always_comb begin
        st_next = st_reg;
        st_next.wake_d = wake_inputs_i;
        st_next.wake_lvl = wake_inputs_i;
        st_next.mcu_uv_d = analog_i.mcu_uv;
        if (ien_wr_i) begin
            st_next.ien = ien_data_i;
        end

        // Mode changes by software, wake from Sleep and battery loss
        if (cfg_i.mode_wr) begin
            st_next.mode = cfg_i.mode;
        end
        if (st_reg.mode == SCM_SLEEP && wake_evt) begin
            st_next.mode = SCM_NORMAL_REQ;
        end
        if (!analog_i.bat_present) begin
            st_next.mode = SCM_EMERGENCY;
        end

        // Reset pulse generator
        if (analog_i.mcu_uv && !st_reg.mcu_uv_d) begin
            st_next.rst_drive = 1'b1;
            st_next.rst_cnt = '0;
        end else if (st_reg.rst_drive) begin
            if (st_reg.rst_cnt == `SCM_RST_CNT_W'(`SCM_RST_CYCLES - 1)) begin
                st_next.rst_drive = 1'b0;
                st_next.mode = SCM_NORMAL_REQ;
            end else begin
                st_next.rst_cnt = st_reg.rst_cnt +
                    `SCM_RST_CNT_W'(1);
            end
        end

        // Partner-driven reset: line low while we do not pull it
        if (!st_reg.rst_drive && !mcu_rst_n_i) begin
            st_next.ext_rst_seen = 1'b1;
        end else if (st_reg.ext_rst_seen && mcu_rst_n_i) begin
            st_next.ext_rst_seen = 1'b0;
            st_next.mode = SCM_NORMAL_REQ;
        end

        // Thermal latches
        if (analog_i.mcu_shut) begin
            st_next.mcu_shut_latch = 1'b1;
        end else if (!analog_i.mcu_warn) begin
            st_next.mcu_shut_latch = 1'b0;
        end
        if (analog_i.per_shut) begin
            st_next.per_shut_latch = 1'b1;
            st_next.per_sw_en = 1'b0;
        end else if (cfg_i.per_enable_wr) begin
            st_next.per_shut_latch = 1'b0;
            st_next.per_sw_en = 1'b1;
        end
        if (analog_i.sw_shut) begin
            st_next.sw_ot_latch = 1'b1;
        end else if (!analog_i.sw_warn) begin
            st_next.sw_ot_latch = 1'b0;
        end

        // Cyclic sense counter in ms, reset outside Sleep
        if (st_reg.mode != SCM_SLEEP) begin
            st_next.cy_cnt = '0;
        end else if (ms_tick) begin
            if (st_reg.cy_cnt >= cy_period - 14'h0001) begin
                st_next.cy_cnt = '0;
            end else begin
                st_next.cy_cnt = st_reg.cy_cnt + 14'h0001;
            end
        end

        mcu_on = 1'b0;
        unique case (st_reg.mode)
            SCM_NORMAL_REQ, SCM_NORMAL, SCM_STANDBY: mcu_on = 1'b1;
            SCM_SLEEP, SCM_EMERGENCY: mcu_on = 1'b0;
            default: mcu_on = 1'b0;
        endcase
        if (st_reg.rst_drive) begin
            mcu_on = 1'b1;
        end
        if (st_reg.mcu_shut_latch || analog_i.mcu_shut ||
                !analog_i.bat_present) begin
            mcu_on = 1'b0;
        end

        per_on = st_reg.mode == SCM_NORMAL && st_reg.per_sw_en &&
            !st_reg.per_shut_latch && !analog_i.per_shut && mcu_on;

        sw_on = 1'b0;
        unique case (st_reg.mode)
            SCM_NORMAL: sw_on = cfg_i.sw_normal_on;
            SCM_STANDBY: sw_on = cfg_i.sw_standby_on;
            SCM_SLEEP: sw_on = cfg_i.sw_sleep_cyclic &&
                st_reg.cy_cnt < 14'(`SCM_CY_ON_MS);
            SCM_NORMAL_REQ, SCM_EMERGENCY: sw_on = 1'b0;
            default: sw_on = 1'b0;
        endcase
        // Sleep keeps the switch alive off the battery only
        if (st_reg.mode != SCM_SLEEP && !mcu_on) begin
            sw_on = 1'b0;
        end
        if (st_reg.per_shut_latch || st_reg.sw_ot_latch ||
                analog_i.sw_shut) begin
            sw_on = 1'b0;
        end

        st_next.mcu_en = mcu_on;
        st_next.per_en = per_on;
        st_next.sw_en = sw_on;
        st_next.irq_n = ~|(pend & st_reg.ien);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
            st_reg.mode <= SCM_NORMAL_REQ;
            st_reg.rst_drive <= 1'b1;
            st_reg.ien <= `SCM_IEN_RESET;
            st_reg.irq_n <= 1'b1;
            st_reg.mcu_en <= 1'b1;
            st_reg.mcu_uv_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Flags sit in flip-flops inside the flag cells
    assign flags_o = fl_q;
    assign mode_o = st_reg.mode;
    assign wake_level_o = st_reg.wake_lvl;
    assign interrupt_enable_reg_o = st_reg.ien;
    assign irq_line_n_o = st_reg.irq_n;
    assign mcu_rst_n_o = 1'b0;
    assign mcu_rst_n_oe_o = st_reg.rst_drive;
    assign mcu_regulator_en_o = st_reg.mcu_en;
    assign peripheral_regulator_en_o = st_reg.per_en;
    assign battery_switch_en_o = st_reg.sw_en;
endmodule
`default_nettype wire

// *** verif/scm_props.sv ***
// Concurrent checks on the supply control block ports
`timescale 1ns/1ps
`default_nettype none
`include "scm_consts.svh"
module scm_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Inputs
    input wire scm_pkg::scm_analog_s analog_i,
    input wire logic ien_wr_i,
    input wire logic [`SCM_IRQ_W-1:0] ien_data_i,
    input wire scm_pkg::scm_flags_s flag_clr_i,
    // Outputs
    input wire scm_pkg::scm_flags_s flags_o,
    input wire scm_pkg::scm_mode_e mode_o,
    input wire logic [`SCM_IRQ_W-1:0] interrupt_enable_reg_o,
    input wire logic irq_line_n_o,
    input wire logic mcu_rst_n_oe_o,
    input wire logic mcu_regulator_en_o,
    input wire logic peripheral_regulator_en_o,
    input wire logic battery_switch_en_o
);
    import scm_pkg::*;
    localparam int LMIN = 99990;
    localparam int LMAX = 100010;
    logic [16:0] ocnt_reg;
    logic [7:0] pend;
    assign pend = {flags_o.sw_ot, flags_o.wake, flags_o.per_uv,
        flags_o.per_warn, flags_o.mcu_shut, flags_o.mcu_warn,
        flags_o.bat_high, flags_o.bat_low} & interrupt_enable_reg_o;
    // Pulse length, too long for a repetition count
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !mcu_rst_n_oe_o) begin
            ocnt_reg <= '0;
        end else begin
            ocnt_reg <= ocnt_reg + 17'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_rst_long: assert property ($fell(mcu_rst_n_oe_o) |->
        $past(ocnt_reg) >= LMIN) else $error("reset pulse short");
    chk_rst_short: assert property (ocnt_reg <= LMAX)
        else $error("reset pulse long");
    chk_irq_or: assert property (irq_line_n_o == !$past(|pend))
        else $error("irq line wrong");
    chk_flag_sticky: assert property ((~flags_o & $past(flags_o) &
        ~$past(flag_clr_i)) == '0) else $error("flag dropped");
    chk_ien_write: assert property (ien_wr_i |=>
        interrupt_enable_reg_o == $past(ien_data_i)) else $error("ien");
    chk_bat_low: assert property (analog_i.bat_low |=>
        flags_o.bat_low) else $error("bat low flag");
    chk_bat_high: assert property (analog_i.bat_high |=>
        flags_o.bat_high) else $error("bat high flag");
    chk_sleep_off: assert property (mode_o == SCM_SLEEP [*2] |->
        !mcu_regulator_en_o) else $error("mcu on in sleep");
    chk_per_normal: assert property (peripheral_regulator_en_o |->
        mode_o == SCM_NORMAL || $past(mode_o) == SCM_NORMAL)
        else $error("per on outside normal");
    chk_sw_nreq: assert property (mode_o == SCM_NORMAL_REQ [*2] |->
        !battery_switch_en_o) else $error("switch on in nreq");
    // Sleep cyclic sense powers the switch while the rail is off
    chk_sw_mcu_off: assert property ((!mcu_regulator_en_o &&
        mode_o != SCM_SLEEP) [*2] |-> !battery_switch_en_o)
        else $error("switch on, mcu off");
    cover property (!irq_line_n_o);
    cover property ($rose(peripheral_regulator_en_o));
    cover property ($fell(mcu_rst_n_oe_o));
    cover property (mode_o == SCM_SLEEP && battery_switch_en_o);
endmodule
bind scm_top scm_props u_scm_props (.clk_i, .sys_rst_i, .analog_i,
    .ien_wr_i, .ien_data_i, .flag_clr_i, .flags_o, .mode_o,
    .interrupt_enable_reg_o, .irq_line_n_o, .mcu_rst_n_oe_o,
    .mcu_regulator_en_o, .peripheral_regulator_en_o,
    .battery_switch_en_o);
`default_nettype wire

// *** verif/scm_mcu_model.sv ***
// Microcontroller side of the open-drain reset line
`timescale 1ns/1ps
`default_nettype none
module scm_mcu_model (
    // Clock
    input wire logic clk_i,
    // Device side
    input wire logic rst_dat_i,
    input wire logic rst_oe_i,
    // Request to hold the line low
    input wire logic hold_i,
    // Wire level, pulled up when nobody drives
    output logic rst_line_o
);
    logic pull_reg;
    // Pull and release on clock edges only
    always_ff @(posedge clk_i) begin
        pull_reg <= hold_i;
    end
    assign rst_line_o = !((rst_oe_i && !rst_dat_i) || pull_reg);
endmodule
`default_nettype wire

// *** verif/scm_top_tb.sv ***
// Self-checking bench for the supply control block
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
    end end
module scm_top_tb;
    import scm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    scm_analog_s an;
    scm_cfg_s cfg;
    scm_flags_s clr, flags;
    scm_mode_e mode;
    logic [2:0] wk, wlv;
    logic [7:0] ien_d, ien_q;
    logic ien_wr, hold, line, r_o, r_oe, irq_n, mcu, per, sw;
    int miscompares = 0;
    int num_checks = 0;
    int ncyc = 0;
    scm_top u_scm_top (.clk_i(clk), .sys_rst_i(rst), .analog_i(an),
        .wake_inputs_i(wk), .mcu_rst_n_i(line), .mcu_rst_n_o(r_o),
        .mcu_rst_n_oe_o(r_oe), .cfg_i(cfg), .ien_wr_i(ien_wr),
        .ien_data_i(ien_d), .flag_clr_i(clr), .flags_o(flags),
        .mode_o(mode), .wake_level_o(wlv), .interrupt_enable_reg_o(ien_q),
        .irq_line_n_o(irq_n), .mcu_regulator_en_o(mcu),
        .peripheral_regulator_en_o(per), .battery_switch_en_o(sw));
    scm_mcu_model u_scm_mcu_model (.clk_i(clk), .rst_dat_i(r_o),
        .rst_oe_i(r_oe), .hold_i(hold), .rst_line_o(line));
    always #5 clk = ~clk;
    task finish_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Limit: boot pulse plus about a thousand cycles, the tests take about a hundred
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 101000) begin
            miscompares++;
            finish_test();
        end
    end
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wmode(input scm_mode_e m);
        cfg.mode = m;
        cfg.mode_wr = 1'b1;
        cyc(1);
        cfg.mode_wr = 1'b0;
        cyc(3);
    endtask
    task wien(input logic [7:0] d);
        ien_d = d;
        ien_wr = 1'b1;
        cyc(1);
        ien_wr = 1'b0;
        cyc(2);
    endtask
    task clr_all;
        clr = '1;
        cyc(1);
        clr = '0;
        cyc(3);
    endtask
    task t_boot;
        int n;
        n = 0;
        `CK("mcu", 1'b1, mcu)
        `CK("per", 1'b0, per)
        `CK("ien", 8'h00, ien_q)
        while (r_oe === 1'b1 && n < 100100) begin
            cyc(1);
            n++;
        end
        `CK("len", 1'b1, (n > 99980 && n < 100020))
        `CK("line", 1'b1, line)
    endtask
    task t_irq;
        wien(8'h01);
        `CK("ien", 8'h01, ien_q)
        an.bat_low = 1'b1;
        an.bat_high = 1'b1;
        an.per_uv = 1'b1;
        an.per_warn = 1'b1;
        cyc(1);
        an.bat_low = 1'b0;
        an.bat_high = 1'b0;
        an.per_uv = 1'b0;
        an.per_warn = 1'b0;
        cyc(4);
        `CK("puv", 1'b1, flags.per_uv)
        `CK("pwarn", 1'b1, flags.per_warn)
        `CK("low", 1'b1, flags.bat_low)
        `CK("high", 1'b1, flags.bat_high)
        `CK("irq", 1'b0, irq_n)
        `CK("mcu", 1'b1, mcu)
        clr.bat_low = 1'b1;
        cyc(1);
        clr = '0;
        cyc(3);
        `CK("irq", 1'b1, irq_n)
        `CK("high", 1'b1, flags.bat_high)
        clr_all();
    endtask
    task t_modes;
        cfg.sw_normal_on = 1'b1;
        cfg.sw_standby_on = 1'b1;
        cfg.per_enable_wr = 1'b1;
        cyc(1);
        cfg.per_enable_wr = 1'b0;
        wmode(SCM_NORMAL);
        `CK("per", 1'b1, per)
        `CK("sw", 1'b1, sw)
        an.per_shut = 1'b1;
        cyc(3);
        an.per_shut = 1'b0;
        `CK("per", 1'b0, per)
        `CK("sw", 1'b0, sw)
        `CK("pshut", 1'b1, flags.per_shut)
        cyc(4);
        `CK("per", 1'b0, per)
        cfg.per_enable_wr = 1'b1;
        cyc(1);
        cfg.per_enable_wr = 1'b0;
        cyc(3);
        `CK("per", 1'b1, per)
        cfg.sw_normal_on = 1'b0;
        cyc(3);
        `CK("sw", 1'b0, sw)
        wmode(SCM_STANDBY);
        `CK("per", 1'b0, per)
        `CK("sw", 1'b1, sw)
        clr_all();
    endtask
    task t_heat;
        an.sw_shut = 1'b1;
        cyc(3);
        an.sw_shut = 1'b0;
        `CK("sw", 1'b0, sw)
        `CK("swot", 1'b1, flags.sw_ot)
        cyc(3);
        `CK("sw", 1'b1, sw)
        an.mcu_warn = 1'b1;
        an.mcu_shut = 1'b1;
        cyc(3);
        `CK("mcu", 1'b0, mcu)
        `CK("sw", 1'b0, sw)
        `CK("mshut", 1'b1, flags.mcu_shut)
        `CK("mwarn", 1'b1, flags.mcu_warn)
        an.mcu_shut = 1'b0;
        an.mcu_warn = 1'b0;
        cyc(3);
        `CK("mcu", 1'b1, mcu)
        clr_all();
    endtask
    task t_line_in;
        hold = 1'b1;
        cyc(4);
        hold = 1'b0;
        cyc(4);
        `CK("mode", SCM_NORMAL_REQ, mode)
        `CK("sw", 1'b0, sw)
    endtask
    task t_sleep;
        wien(8'h40);
        cfg.wake_en = 3'h1;
        wmode(SCM_SLEEP);
        cyc(2);
        `CK("mcu", 1'b0, mcu)
        `CK("sw", 1'b0, sw)
        cfg.sw_sleep_cyclic = 1'b1;
        cyc(2);
        `CK("sw", 1'b1, sw)
        wk = 3'h1;
        cyc(4);
        `CK("wake", 1'b1, flags.wake)
        `CK("irq", 1'b0, irq_n)
        `CK("mcu", 1'b1, mcu)
        clr_all();
        wk = 3'h5;
        cyc(3);
        `CK("lvl", 3'h5, wlv)
    endtask
    task t_power;
        an.bat_present = 1'b0;
        cyc(3);
        `CK("mode", SCM_EMERGENCY, mode)
        `CK("mcu", 1'b0, mcu)
        an.bat_present = 1'b1;
        an.mcu_uv = 1'b1;
        cyc(3);
        `CK("oe", 1'b1, r_oe)
        `CK("rdat", 1'b0, r_o)
        `CK("line", 1'b0, line)
        `CK("uvrst", 1'b1, flags.mcu_uv_reset)
    endtask
    initial begin
        an = '0;
        an.bat_present = 1'b1;
        cfg = '0;
        clr = '0;
        wk = '0;
        ien_d = '0;
        ien_wr = 1'b0;
        hold = 1'b0;
        cyc(16);
        rst = 1'b0;
        cyc(1);
        t_boot();
        t_irq();
        t_modes();
        t_heat();
        t_line_in();
        t_sleep();
        t_power();
        finish_test();
    end
endmodule
`default_nettype wire
